// [hdl/srmc_cfg.svh]
`ifndef SRMC_CFG_SVH
`define SRMC_CFG_SVH
// Standby control word layout and protection key.
`define SRMC_KEY 16'h1acc
`define SRMC_KEY_HI 31
`define SRMC_KEY_LO 16
`define SRMC_TYPE_HI 1
`define SRMC_TYPE_LO 0
`define SRMC_DEEPSTBY_BIT 2
`define SRMC_PINSEL_BIT 4
`define SRMC_RTCEN_BIT 0
`define SRMC_TYPE_TIMER 2'h0
`define SRMC_TYPE_RTC 2'h2
// Register selects on the device's own write port.
`define SRMC_SEL_STB 1'h0
`define SRMC_SEL_RTC 1'h1
// Saved clock mode codes.
`define SRMC_MODE_HSCR 3'h0
`define SRMC_MODE_MAIN 3'h1
`define SRMC_MODE_PLL 3'h2
`define SRMC_MODE_LSCR 3'h4
`define SRMC_MODE_SUB 3'h5
// Oscillator enable bit positions: hsCr, main, pll, lsCr, sub.
`define SRMC_OSC_ALL 5'h1f
`define SRMC_OSC_SUB 5'h10
// Regulator settle time in microseconds and system clock in MHz.
`define SRMC_REG_STAB_US 300
`define SRMC_CLK_MHZ 250
// Controller register map on APB.
`define SRMC_APB_CMD 12'h000
`define SRMC_APB_STATUS 12'h004
`define SRMC_CMD_TIMER 0
`define SRMC_CMD_RTC 1
`define SRMC_CMD_PINSEL 4
`endif

// [hdl/srmc_pkg.sv]
package srmc_pkg;
  typedef enum logic [2:0] {
    SRMC_RUN = 3'h0,
    SRMC_TIMER = 3'h1,
    SRMC_RTC = 3'h2,
    SRMC_REGWAIT = 3'h3,
    SRMC_OSCWAIT = 3'h4
  } srmc_dev_state_t;

  typedef enum logic [2:0] {
    SRMC_H_IDLE = 3'h0,
    SRMC_H_CLEAR = 3'h1,
    SRMC_H_FLASH = 3'h2,
    SRMC_H_WRRTC = 3'h3,
    SRMC_H_WRSTB = 3'h4,
    SRMC_H_SLEEP = 3'h5,
    SRMC_H_WAKE = 3'h6
  } srmc_host_state_t;

  typedef logic [2:0] srmc_clkmode_t;
endpackage

// [hdl/srmc_if.sv]
`timescale 1ns/1ns
interface srmc_if;
  // Controller to device.
  logic regWrEn;
  logic regSel;
  logic [31:0] regWdata;
  logic deepSleepRequest;
  logic waitForInterruptInstr;
  // Device to controller.
  logic cpuRunning;
  logic inStandby;
  logic wakeCausePending;
  logic subOscReadyFlag;
  logic rtcModeEnable;
  logic [1:0] standbyTypeField;
  srmc_pkg::srmc_clkmode_t clockModeStatus;
  modport dev (input regWrEn, regSel, regWdata, deepSleepRequest, waitForInterruptInstr,
    output cpuRunning, inStandby, wakeCausePending, subOscReadyFlag, rtcModeEnable, standbyTypeField,
    clockModeStatus);
  modport host (output regWrEn, regSel, regWdata, deepSleepRequest, waitForInterruptInstr,
    input cpuRunning, inStandby, wakeCausePending, subOscReadyFlag, rtcModeEnable, standbyTypeField,
    clockModeStatus);
endinterface

// [hdl/srmc_device.sv]
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "srmc_cfg.svh"
// Overview of operation
// - Timer mode stops CPU, AHB, APB clocks, debug.
// - Only watchdog, watch, RTC, supervisor, LVD run.
// - External bus halted in timer mode.
// - Pin select chooses hold or high impedance.
// - Timer entry: clear enable, key, type, sleep.
// - Timer variant follows current master clock.
// - Valid timer resets return to fast CR.
// - Software watchdog reset cannot wake timer mode.
// - Listed interrupts wake timer to saved mode.
// - Interrupt wake run mode follows saved code.
// - Reset waits oscillators; interrupt resumes directly.
// - Slow timer variants add regulator settle delay.
// - Low priority wake restarts clocks, CPU stays.
// - Controller clears pending wake causes before entry.
// - Controller waits flash completion before slow entry.
// - RTC mode keeps only sub oscillator running.
// - RTC entry needs sub ready, key, type.
// - Only pin and low voltage resets wake RTC.
// - Listed interrupts wake RTC to saved mode.
// - Debugger cannot resume a stopped standby CPU.
// - RTC exit applies regulator settle delay.
module srmc_device
  import srmc_pkg::*;
#(
  parameter int RegStabCycles = `SRMC_REG_STAB_US * `SRMC_CLK_MHZ
)(
  input wire logic sys_clk,
  input wire logic reset_n,
  srmc_if.dev link,
  input wire logic externalResetPin_n,
  input wire logic lowVoltReset,
  input wire logic hwWatchdogReset,
  input wire logic clockSupervisorReset,
  input wire logic anomFreqReset,
  input wire logic swWatchdogReset,
  input wire logic nmiIrq,
  input wire logic extIrq,
  input wire logic hwWatchdogIrq,
  input wire logic usbWakeIrq,
  input wire logic watchCounterIrq,
  input wire logic rtcIrq,
  input wire logic lowVoltIrq,
  input wire logic irqPriorityOk,
  input wire logic debugResumeReq,
  input wire logic subOscReady,
  input wire logic hsCrReady,
  input wire logic lsCrReady,
  input wire srmc_pkg::srmc_clkmode_t masterClockMode,
  output logic cpuClkEn,
  output logic ahbClkEn,
  output logic apbClkEn,
  output logic debugEn,
  output logic extBusEn,
  output logic periphFreeze,
  output logic pinHold,
  output logic pinHighZ,
  output logic [4:0] oscEn,
  output srmc_pkg::srmc_clkmode_t runMode,
  output srmc_pkg::srmc_clkmode_t timerVariant,
  output logic systemResetPulse
);
  import srmc_pkg::*;

  localparam int CntW = $clog2(RegStabCycles + 1);

  typedef struct packed {
    logic pinS1;
    logic pinS2;
    logic pinS3;
    logic pinLevel;
    srmc_dev_state_t state;
    logic byReset;
    logic [CntW-1:0] count;
    logic [1:0] stbType;
    logic deepStby;
    logic pinSel;
    logic rtcEn;
    srmc_clkmode_t saved;
    srmc_clkmode_t runMode;
    logic cpuClk;
    logic busClk;
    logic standby;
    logic [4:0] oscEn;
    logic pinHold;
    logic pinHighZ;
    logic rstPulse;
    logic pending;
    logic subReady;
  } srmc_dev_reg_t;

  srmc_dev_reg_t q, d;

  // Tells whether a saved clock mode is one of the slow variants needing a regulator settle.
  function automatic logic srmc_slow(input srmc_clkmode_t code);
    srmc_slow = (code == `SRMC_MODE_LSCR) || (code == `SRMC_MODE_SUB);
  endfunction

  // Tells whether the anomalous frequency detector is armed for the saved mode.
  function automatic logic srmc_anom_ok(input srmc_clkmode_t code);
    srmc_anom_ok = (code == `SRMC_MODE_MAIN) || (code == `SRMC_MODE_PLL);
  endfunction

  logic pinReset;
  logic timerRstWake;
  logic timerIrqWake;
  logic rtcRstWake;
  logic rtcIrqWake;
  logic keyOk;

  // Qualified wake sources; software watchdog reset is deliberately absent.
  always_comb
  begin
    pinReset = !q.pinLevel;
    timerRstWake = pinReset || lowVoltReset || hwWatchdogReset || clockSupervisorReset
      || (anomFreqReset && srmc_anom_ok(q.saved));
    timerIrqWake = nmiIrq || extIrq || hwWatchdogIrq || usbWakeIrq || watchCounterIrq || rtcIrq
      || lowVoltIrq || (anomFreqReset && srmc_anom_ok(q.saved));
    rtcRstWake = pinReset || lowVoltReset;
    rtcIrqWake = nmiIrq || extIrq || usbWakeIrq || watchCounterIrq || rtcIrq || lowVoltIrq;
    keyOk = link.regWdata[`SRMC_KEY_HI:`SRMC_KEY_LO] == `SRMC_KEY;
  end

  // Next state: synchroniser, register writes and the standby sequencer.
  always_comb
  begin
    d = q;
    d.pinS1 = externalResetPin_n;
    d.pinS2 = q.pinS1;
    d.pinS3 = q.pinS2;
    if (q.pinS2 == q.pinS3)
    begin
      d.pinLevel = q.pinS3;
    end
    d.subReady = subOscReady;
    d.pending = nmiIrq || extIrq || hwWatchdogIrq || usbWakeIrq || watchCounterIrq || rtcIrq || lowVoltIrq;
    d.rstPulse = 1'b0;
    if (link.regWrEn && q.state == SRMC_RUN)
    begin
      if (link.regSel == `SRMC_SEL_RTC)
      begin
        d.rtcEn = link.regWdata[`SRMC_RTCEN_BIT];
      end
      else if (keyOk)
      begin
        d.stbType = link.regWdata[`SRMC_TYPE_HI:`SRMC_TYPE_LO];
        d.deepStby = link.regWdata[`SRMC_DEEPSTBY_BIT];
        d.pinSel = link.regWdata[`SRMC_PINSEL_BIT];
      end
    end
    case (q.state)
      SRMC_RUN:
      begin
        // A late wake with too low a priority leaves the CPU stopped until priority allows it.
        if (!q.cpuClk && q.busClk && irqPriorityOk)
        begin
          d.cpuClk = 1'b1;
        end
        if (link.waitForInterruptInstr && link.deepSleepRequest && q.cpuClk && !q.deepStby)
        begin
          if (q.stbType == `SRMC_TYPE_TIMER && !q.rtcEn)
          begin
            d.state = SRMC_TIMER;
            d.saved = masterClockMode;
            d.oscEn = `SRMC_OSC_ALL;
          end
          else if (q.stbType == `SRMC_TYPE_RTC && q.rtcEn)
          begin
            d.state = SRMC_RTC;
            d.saved = masterClockMode;
            d.oscEn = `SRMC_OSC_SUB;
          end
          if ((q.stbType == `SRMC_TYPE_TIMER && !q.rtcEn) || (q.stbType == `SRMC_TYPE_RTC && q.rtcEn))
          begin
            d.cpuClk = 1'b0;
            d.busClk = 1'b0;
            d.standby = 1'b1;
            d.pinHold = !q.pinSel;
            d.pinHighZ = q.pinSel;
          end
        end
      end
      SRMC_TIMER, SRMC_RTC:
      begin
        // A debugger request is never a wake source here.
        if ((q.state == SRMC_TIMER) ? (timerRstWake || timerIrqWake) : (rtcRstWake || rtcIrqWake))
        begin
          d.byReset = (q.state == SRMC_TIMER) ? timerRstWake : rtcRstWake;
          d.oscEn = `SRMC_OSC_ALL;
          d.count = '0;
          if (q.state == SRMC_RTC || srmc_slow(q.saved))
          begin
            d.state = SRMC_REGWAIT;
          end
          else if (timerRstWake)
          begin
            d.state = SRMC_OSCWAIT;
          end
          else
          begin
            d.state = SRMC_RUN;
            d.runMode = q.saved;
            d.busClk = 1'b1;
            d.cpuClk = irqPriorityOk;
            d.standby = 1'b0;
            d.pinHold = 1'b0;
            d.pinHighZ = 1'b0;
          end
        end
      end
      SRMC_REGWAIT:
      begin
        d.count = q.count + 1'b1;
        if (q.count == CntW'(RegStabCycles - 1))
        begin
          d.state = q.byReset ? SRMC_OSCWAIT : SRMC_RUN;
          if (!q.byReset)
          begin
            d.runMode = q.saved;
            d.busClk = 1'b1;
            d.cpuClk = irqPriorityOk;
            d.standby = 1'b0;
            d.pinHold = 1'b0;
            d.pinHighZ = 1'b0;
          end
        end
      end
      SRMC_OSCWAIT:
      begin
        if (hsCrReady && lsCrReady)
        begin
          d.state = SRMC_RUN;
          d.runMode = `SRMC_MODE_HSCR;
          d.rstPulse = 1'b1;
          d.busClk = 1'b1;
          d.cpuClk = 1'b1;
          d.standby = 1'b0;
          d.pinHold = 1'b0;
          d.pinHighZ = 1'b0;
          d.stbType = `SRMC_TYPE_TIMER;
          d.deepStby = 1'b0;
          d.pinSel = 1'b0;
          d.rtcEn = 1'b0;
        end
      end
      default:
      begin
        d.state = SRMC_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '{pinS1: 1'b1, pinS2: 1'b1, pinS3: 1'b1, pinLevel: 1'b1, state: SRMC_RUN, byReset: 1'b0,
        count: '0, stbType: `SRMC_TYPE_TIMER, deepStby: 1'b0, pinSel: 1'b0, rtcEn: 1'b0, saved: `SRMC_MODE_HSCR,
        runMode: `SRMC_MODE_HSCR, cpuClk: 1'b1, busClk: 1'b1, standby: 1'b0, oscEn: `SRMC_OSC_ALL,
        pinHold: 1'b0, pinHighZ: 1'b0, rstPulse: 1'b0, pending: 1'b0, subReady: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign cpuClkEn = q.cpuClk;
  assign ahbClkEn = q.busClk;
  assign apbClkEn = q.busClk;
  assign debugEn = q.busClk;
  assign extBusEn = q.busClk;
  assign periphFreeze = q.standby;
  assign pinHold = q.pinHold;
  assign pinHighZ = q.pinHighZ;
  assign oscEn = q.oscEn;
  assign runMode = q.runMode;
  assign timerVariant = q.saved;
  assign systemResetPulse = q.rstPulse;
  assign link.cpuRunning = q.cpuClk;
  assign link.inStandby = q.standby;
  assign link.wakeCausePending = q.pending;
  assign link.subOscReadyFlag = q.subReady;
  assign link.rtcModeEnable = q.rtcEn;
  assign link.standbyTypeField = q.stbType;
  assign link.clockModeStatus = q.runMode;
endmodule // srmc_device

// [hdl/srmc_host.sv]
`timescale 1ns/1ns
`include "srmc_cfg.svh"
module srmc_host
  import srmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  srmc_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic flashBusy,
  output logic clearWakeCauses
);
  import srmc_pkg::*;

  typedef struct packed {
    srmc_host_state_t state;
    logic toRtc;
    logic pinSel;
    logic refused;
    logic regWrEn;
    logic regSel;
    logic [31:0] regWdata;
    logic deepSleep;
    logic waitInstr;
    logic clear;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } srmc_host_reg_t;

  srmc_host_reg_t q, d;

  // Builds the keyed standby control word.
  function automatic logic [31:0] srmc_stb_word(input logic [1:0] stbType, input logic pinSel);
    srmc_stb_word = '0;
    srmc_stb_word[`SRMC_KEY_HI:`SRMC_KEY_LO] = `SRMC_KEY;
    srmc_stb_word[`SRMC_TYPE_HI:`SRMC_TYPE_LO] = stbType;
    srmc_stb_word[`SRMC_DEEPSTBY_BIT] = 1'b0;
    srmc_stb_word[`SRMC_PINSEL_BIT] = pinSel;
  endfunction

  logic setup;
  logic cmdWrite;

  // APB decode; read data and error are prepared in the setup cycle.
  always_comb
  begin
    setup = psel && !penable;
    cmdWrite = psel && penable && pwrite && paddr == `SRMC_APB_CMD;
  end

  // Next state: register answers and the entry sequence.
  always_comb
  begin
    d = q;
    d.pready = 1'b1;
    d.regWrEn = 1'b0;
    d.waitInstr = 1'b0;
    d.clear = 1'b0;
    if (setup)
    begin
      d.pslverr = paddr != `SRMC_APB_CMD && paddr != `SRMC_APB_STATUS;
      d.prdata = '0;
      if (!pwrite && paddr == `SRMC_APB_STATUS)
      begin
        d.prdata = {17'h00000, link.standbyTypeField, link.rtcModeEnable, link.subOscReadyFlag,
          link.clockModeStatus, link.inStandby, link.cpuRunning, q.refused, 1'b0, q.state, 1'b0};
      end
    end
    case (q.state)
      SRMC_H_IDLE:
      begin
        if (cmdWrite && (pwdata[`SRMC_CMD_TIMER] || pwdata[`SRMC_CMD_RTC]))
        begin
          d.toRtc = pwdata[`SRMC_CMD_RTC];
          d.pinSel = pwdata[`SRMC_CMD_PINSEL];
          d.refused = pwdata[`SRMC_CMD_RTC] && !link.subOscReadyFlag;
          d.state = (pwdata[`SRMC_CMD_RTC] && !link.subOscReadyFlag) ? SRMC_H_IDLE : SRMC_H_CLEAR;
        end
      end
      SRMC_H_CLEAR:
      begin
        d.clear = link.wakeCausePending;
        if (!link.wakeCausePending && !q.clear)
        begin
          d.state = SRMC_H_FLASH;
        end
      end
      SRMC_H_FLASH:
      begin
        if (!flashBusy)
        begin
          d.state = SRMC_H_WRRTC;
          d.regWrEn = 1'b1;
          d.regSel = `SRMC_SEL_RTC;
          d.regWdata = {31'h00000000, q.toRtc};
        end
      end
      SRMC_H_WRRTC:
      begin
        d.state = SRMC_H_WRSTB;
        d.regWrEn = 1'b1;
        d.regSel = `SRMC_SEL_STB;
        d.regWdata = srmc_stb_word(q.toRtc ? `SRMC_TYPE_RTC : `SRMC_TYPE_TIMER, q.pinSel);
      end
      SRMC_H_WRSTB:
      begin
        d.state = SRMC_H_SLEEP;
        d.deepSleep = 1'b1;
      end
      SRMC_H_SLEEP:
      begin
        d.state = SRMC_H_WAKE;
        d.waitInstr = 1'b1;
      end
      SRMC_H_WAKE:
      begin
        if (link.cpuRunning && !link.inStandby)
        begin
          d.deepSleep = 1'b0;
          d.state = SRMC_H_IDLE;
        end
      end
      default:
      begin
        d.state = SRMC_H_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '{state: SRMC_H_IDLE, toRtc: 1'b0, pinSel: 1'b0, refused: 1'b0, regWrEn: 1'b0, regSel: 1'b0,
        regWdata: '0, deepSleep: 1'b0, waitInstr: 1'b0, clear: 1'b0, prdata: '0, pready: 1'b0,
        pslverr: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign clearWakeCauses = q.clear;
  assign link.regWrEn = q.regWrEn;
  assign link.regSel = q.regSel;
  assign link.regWdata = q.regWdata;
  assign link.deepSleepRequest = q.deepSleep;
  assign link.waitForInterruptInstr = q.waitInstr;
endmodule // srmc_host

// [testbench/srmc_chk.sv]
`timescale 1ns/1ns
`include "srmc_cfg.svh"
module srmc_chk
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic regWrEn,
  input wire logic regSel,
  input wire logic [31:0] regWdata,
  input wire logic deepSleepRequest,
  input wire logic waitForInterruptInstr,
  input wire logic cpuRunning,
  input wire logic inStandby,
  input wire logic wakeCausePending,
  input wire logic subOscReadyFlag,
  input wire logic rtcModeEnable,
  input wire logic [1:0] standbyTypeField
);
  // All checks run on the system clock and stay quiet in reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // The device is in RUN, and the type and enable form a legal standby pair.
  logic runOk;
  logic typeOk;
  assign runOk = cpuRunning && !inStandby;
  assign typeOk = (standbyTypeField == `SRMC_TYPE_TIMER && !rtcModeEnable) ||
    (standbyTypeField == `SRMC_TYPE_RTC && rtcModeEnable);
  a_entry_taken: assert property (waitForInterruptInstr && deepSleepRequest && runOk && typeOk |=> inStandby)
    else $error("standby entry not taken");
  a_entry_cause: assert property ($rose(inStandby) |-> $past(waitForInterruptInstr))
    else $error("standby entered without wait pulse");
  a_wfi_sleep: assert property (waitForInterruptInstr |-> deepSleepRequest)
    else $error("wait pulse without deep sleep");
  a_wfi_follows: assert property ($rose(deepSleepRequest) |-> ##[0:20] waitForInterruptInstr)
    else $error("no wait pulse after deep sleep");
  a_clean_entry: assert property ($rose(deepSleepRequest) |-> !wakeCausePending)
    else $error("deep sleep with wake cause pending");
  a_sleep_type: assert property ($rose(deepSleepRequest) |=> typeOk)
    else $error("deep sleep with illegal standby setup");
  a_key_write: assert property (regWrEn && !regSel && regWdata[`SRMC_KEY_HI:`SRMC_KEY_LO] == `SRMC_KEY && runOk
    |=> standbyTypeField == $past(regWdata[`SRMC_TYPE_HI:`SRMC_TYPE_LO]))
    else $error("keyed standby write lost");
  a_enable_write: assert property (regWrEn && regSel && runOk
    |=> rtcModeEnable == $past(regWdata[`SRMC_RTCEN_BIT]))
    else $error("rtc enable write lost");
  a_enable_ready: assert property ($rose(rtcModeEnable) |-> $past(subOscReadyFlag))
    else $error("rtc enable set without sub oscillator");
  a_cpu_off: assert property (inStandby |-> !cpuRunning)
    else $error("cpu running in standby");
  // Main scenarios: both entries and a wake.
  c_timer: cover property ($rose(inStandby) && !rtcModeEnable);
  c_rtc: cover property ($rose(inStandby) && rtcModeEnable);
  c_wake: cover property ($fell(inStandby));
endmodule // srmc_chk

// [testbench/standby_timer_rtc_mode_control_tb_top.sv]
`timescale 1ns/1ns
`include "srmc_cfg.svh"
module standby_timer_rtc_mode_control_tb_top;
  import srmc_pkg::*;
  localparam int STAB = 8;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, flashBusy = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, clearWakeCauses, er;
  logic externalResetPin_n = 1'b1, swWatchdogReset = 1'b0, debugResumeReq = 1'b0, irqPriorityOk = 1'b1;
  logic subOscReady = 1'b0, hsCrReady = 1'b1, lsCrReady = 1'b1;
  srmc_clkmode_t masterClockMode = 3'h0;
  logic [6:0] irq = 7'h0;
  logic [3:0] rst = 4'h0;
  logic cpuClkEn, ahbClkEn, apbClkEn, debugEn, extBusEn, periphFreeze, pinHold, pinHighZ, systemResetPulse;
  logic [4:0] oscEn;
  srmc_clkmode_t runMode, timerVariant;
  int num_errors = 0;
  int cmp_count = 0;
  // The 4 ns system clock.
  always #2 sys_clk = ~sys_clk;
  srmc_if link();
  srmc_device #(.RegStabCycles(STAB)) i_srmc_device (.sys_clk, .reset_n, .link(link), .externalResetPin_n,
    .lowVoltReset(rst[0]), .hwWatchdogReset(rst[1]), .clockSupervisorReset(rst[2]), .anomFreqReset(rst[3]),
    .swWatchdogReset, .nmiIrq(irq[0]), .extIrq(irq[1]), .hwWatchdogIrq(irq[2]), .usbWakeIrq(irq[3]),
    .watchCounterIrq(irq[4]), .rtcIrq(irq[5]), .lowVoltIrq(irq[6]), .irqPriorityOk, .debugResumeReq, .subOscReady,
    .hsCrReady, .lsCrReady, .masterClockMode, .cpuClkEn, .ahbClkEn, .apbClkEn, .debugEn, .extBusEn, .periphFreeze,
    .pinHold, .pinHighZ, .oscEn, .runMode, .timerVariant, .systemResetPulse);
  srmc_host i_srmc_host (.sys_clk, .reset_n, .link(link), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .flashBusy, .clearWakeCauses);
  srmc_chk i_srmc_chk (.sys_clk, .reset_n, .regWrEn(link.regWrEn), .regSel(link.regSel), .regWdata(link.regWdata),
    .deepSleepRequest(link.deepSleepRequest), .waitForInterruptInstr(link.waitForInterruptInstr),
    .cpuRunning(link.cpuRunning), .inStandby(link.inStandby), .wakeCausePending(link.wakeCausePending),
    .subOscReadyFlag(link.subOscReadyFlag), .rtcModeEnable(link.rtcModeEnable),
    .standbyTypeField(link.standbyTypeField));
  // Wake sources drop when the controller asks for them to be cleared.
  always @(posedge sys_clk)
    if (clearWakeCauses === 1'b1)
      irq <= 7'h0;
  // Compares one result and counts it.
  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    cmp_count++;
    if (act !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  // One APB transfer, held until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Waits for the standby flag to reach a level, then realigns to a rising edge.
  task automatic wait_sb(input logic v);
    int n;
    n = 0;
    while (link.inStandby !== v && n < 300)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(link.inStandby, v);
    @(posedge sys_clk);
  endtask
  // Counts cycles until the processor clock runs again.
  task automatic until_cpu(output int n);
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (cpuClkEn !== 1'b1 && n < 200);
    @(posedge sys_clk);
  endtask
  // Status reads back its reset value; an unmapped address is refused.
  task automatic t_regs;
    apb(1'b0, `SRMC_APB_STATUS, 32'h0);
    check({er, rd[14:0]}, 16'h0040);
    apb(1'b0, 12'h0f0, 32'h0);
    check(er, 1'b1);
  endtask
  // Timer entry and interrupt wake for every saved clock code and wake source.
  task automatic t_timer;
    srmc_clkmode_t code;
    logic pinSel;
    int n;
    for (int i = 0; i < 7; i++)
    begin
      code = srmc_clkmode_t'(i % 5 > 2 ? i % 5 + 1 : i % 5);
      pinSel = i[0];
      masterClockMode <= code;
      flashBusy <= (code == `SRMC_MODE_LSCR);
      if (i == 0)
        irq <= 7'h10;
      @(posedge sys_clk);
      apb(1'b1, `SRMC_APB_CMD, {27'h0, pinSel, 4'h1});
      repeat (20) @(posedge sys_clk);
      check(link.inStandby, !flashBusy);
      flashBusy <= 1'b0;
      wait_sb(1'b1);
      check({cpuClkEn, ahbClkEn, apbClkEn, debugEn, extBusEn, periphFreeze}, 6'h01);
      check({pinHold, pinHighZ}, {~pinSel, pinSel});
      check(timerVariant, code);
      swWatchdogReset <= 1'b1;
      debugResumeReq <= 1'b1;
      repeat (6) @(posedge sys_clk);
      swWatchdogReset <= 1'b0;
      debugResumeReq <= 1'b0;
      irq <= 7'h1 << i;
      check(link.inStandby, 1'b1);
      until_cpu(n);
      check(code[2] ? n > STAB : n < 5, 1'b1);
      check(runMode, code);
      irq <= 7'h0;
      wait_sb(1'b0);
    end
  endtask
  // A wake whose priority is too low restarts the clocks but not the processor.
  task automatic t_lowprio;
    irqPriorityOk <= 1'b0;
    apb(1'b1, `SRMC_APB_CMD, 32'h1);
    wait_sb(1'b1);
    irq <= 7'h02;
    repeat (6) @(posedge sys_clk);
    check({cpuClkEn, apbClkEn}, 2'b01);
    irqPriorityOk <= 1'b1;
    irq <= 7'h0;
    repeat (6) @(posedge sys_clk);
    check(cpuClkEn, 1'b1);
    wait_sb(1'b0);
  endtask
  // RTC entry is refused without the sub oscillator; in RTC only listed causes wake.
  task automatic t_rtc;
    int n;
    masterClockMode <= `SRMC_MODE_PLL;
    apb(1'b1, `SRMC_APB_CMD, 32'h2);
    repeat (20) @(posedge sys_clk);
    apb(1'b0, `SRMC_APB_STATUS, 32'h0);
    check({rd[5], link.inStandby}, 2'b10);
    subOscReady <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b1, `SRMC_APB_CMD, 32'h2);
    wait_sb(1'b1);
    check({oscEn, cpuClkEn, ahbClkEn, apbClkEn}, {`SRMC_OSC_SUB, 3'b000});
    rst[3:1] <= 3'b111;
    irq <= 7'h04;
    repeat (8) @(posedge sys_clk);
    rst <= 4'h0;
    irq <= 7'h20;
    check(link.inStandby, 1'b1);
    until_cpu(n);
    check(n > STAB, 1'b1);
    check(runMode, `SRMC_MODE_PLL);
    irq <= 7'h0;
    wait_sb(1'b0);
  endtask
  // A reset wake waits for the internal oscillators and returns to the fast internal mode.
  task automatic t_rstwake(input logic [31:0] c, input logic pin);
    int n;
    hsCrReady <= 1'b0;
    apb(1'b1, `SRMC_APB_CMD, c);
    wait_sb(1'b1);
    externalResetPin_n <= ~pin;
    rst[1] <= ~pin;
    repeat (STAB + 8) @(posedge sys_clk);
    externalResetPin_n <= 1'b1;
    rst <= 4'h0;
    hsCrReady <= 1'b1;
    check(cpuClkEn, 1'b0);
    n = 0;
    while (systemResetPulse !== 1'b1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(systemResetPulse, 1'b1);
    @(posedge sys_clk);
    wait_sb(1'b0);
    check(runMode, `SRMC_MODE_HSCR);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Cuts a hang short well after the expected run length.
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop;
  end
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_regs;
    t_timer;
    t_lowprio;
    t_rtc;
    t_rstwake(32'h1, 1'b0);
    t_rstwake(32'h2, 1'b1);
    report_and_stop;
  end
endmodule // standby_timer_rtc_mode_control_tb_top
